// File: src/qmrpr_top.sv
// Functional notes
// - In four-wire mode, read-parameter command sets dummy clocks and wrap length.
// - Dummy field: 00 and 01 give 4, 10 gives 6, 11 gives 8.
// - Wrap field: 00 8 bytes, 01 16, 10 32, 11 64.
// - In standard mode, set-burst-with-wrap bits set the wrap length.
// - Wrapped burst read acts as fast read, address wraps in aligned window.
// - Enable command enters four-wire mode only when quad enable is set.
// - With quad enable clear, the enable command is ignored.
// - Entering four-wire mode keeps latch, suspend flag and wrap length.
// - Disable command returns from four-wire mode to standard operation.
// - Leaving four-wire mode keeps latch, suspend flag and wrap length.
// - Reset needs reset-enable frame, then reset command in a later frame.
// - Reset-enable and reset are accepted in both modes.
// - Accepted reset aborts internal work and returns to power-on state.
// - Accepted reset clears all volatile settings, parameters and wrap bits.
// - After reset, every command is refused for about 30 us.
`timescale 1ns/1ns
`default_nettype none

module qmrpr_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cs_n_pin,
  input  wire logic        sclk_pin,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe
);

  // ---------------------------------------------------------------
  // Pin synchronisers and edge finding
  // ---------------------------------------------------------------
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic       cs_d_reg;
  logic       sclk_d_reg;

  // Two flops before any logic; the link clock is only sampled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg  <= qmrpr_pkg::SYNC_RST;
      sync2_reg  <= qmrpr_pkg::SYNC_RST;
      cs_d_reg   <= 1'b1;
      sclk_d_reg <= 1'b0;
    end else begin
      sync1_reg  <= {cs_n_pin, sclk_pin, io_in};
      sync2_reg  <= sync1_reg;
      cs_d_reg   <= sync2_reg[5];
      sclk_d_reg <= sync2_reg[4];
    end
  end

  wire       cs_n_s      = sync2_reg[5];
  wire       sclk_s      = sync2_reg[4];
  wire [3:0] io_s        = sync2_reg[3:0];
  wire       frame_start = ~cs_n_s & cs_d_reg;
  wire       frame_end   = cs_n_s & ~cs_d_reg;
  wire       sclk_rise   = ~cs_n_s & sclk_s & ~sclk_d_reg;
  wire       sclk_fall   = ~cs_n_s & ~sclk_s & sclk_d_reg;

  // ---------------------------------------------------------------
  // State and configuration registers
  // ---------------------------------------------------------------
  qmrpr_pkg::qmrpr_state_t   state_reg;
  qmrpr_pkg::qmrpr_rdparam_t rdparam_reg;
  qmrpr_pkg::qmrpr_ctrl_t    ctrl_reg;
  logic [2:0]                wrap_bits_reg;
  logic                      qpi_reg;
  logic                      wel_reg;
  logic                      armed_reg;
  logic                      rst_busy_reg;
  logic [11:0]               rst_cnt_reg;
  logic [7:0]                in_sh_reg;
  logic [3:0]                bit_cnt_reg;
  logic [1:0]                byte_cnt_reg;
  logic [3:0]                dummy_cnt_reg;
  logic [7:0]                cmd_reg;
  logic                      cmd_valid_reg;
  logic                      wrap_rd_reg;
  logic [23:0]               addr_reg;
  logic [7:0]                out_sh_reg;
  logic [3:0]                out_cnt_reg;

  // ---------------------------------------------------------------
  // Serial input shifter
  // ---------------------------------------------------------------
  wire [3:0] step     = qpi_reg ? qmrpr_pkg::QPI_STEP : qmrpr_pkg::SPI_STEP;
  wire [7:0] in_next  = qpi_reg ? {in_sh_reg[3:0], io_s}
                                : {in_sh_reg[6:0], io_s[0]};
  wire [3:0] bit_next = bit_cnt_reg + step;
  wire       byte_done = sclk_rise & (bit_next == qmrpr_pkg::BYTE_BITS);

  // Bits are counted in every state; only input states use the byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sh_reg   <= '0;
      bit_cnt_reg <= '0;
    end else if (frame_start) begin
      bit_cnt_reg <= '0;
    end else if (sclk_rise) begin
      in_sh_reg   <= in_next;
      bit_cnt_reg <= byte_done ? 4'h0 : bit_next;
    end
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  wire is_rdparam = (in_next == qmrpr_pkg::CMD_RD_PARAM) & qpi_reg;
  wire is_setwrap = (in_next == qmrpr_pkg::CMD_SET_WRAP) & ~qpi_reg;
  wire is_wraprd  = (in_next == qmrpr_pkg::CMD_WRAP_RD) & qpi_reg;
  wire is_read    = (in_next == qmrpr_pkg::CMD_FAST_RD) | is_wraprd
                  | ((in_next == qmrpr_pkg::CMD_QUAD_RD) & qpi_reg);

  // Dummy field decode; 00 and 01 both mean four clocks
  wire [1:0] dfield    = rdparam_reg.dummy_cycle_field;
  wire [3:0] dummy_qpi = (dfield == 2'h3) ? qmrpr_pkg::DUMMY_8 :
                         (dfield == 2'h2) ? qmrpr_pkg::DUMMY_6 :
                                            qmrpr_pkg::DUMMY_4;
  wire [3:0] dummy_need = qpi_reg ? dummy_qpi : qmrpr_pkg::SPI_DUMMY;
  wire [3:0] dummy_next = dummy_cnt_reg + 4'h1;

  // Frame-end actions; commands act once chip select rises, but parameter and wrap bytes load at their last bit
  wire end_ok   = frame_end & cmd_valid_reg & ~rst_busy_reg;
  wire do_reset = end_ok & (cmd_reg == qmrpr_pkg::CMD_RST) & armed_reg;
  wire do_qpion = end_ok & (cmd_reg == qmrpr_pkg::CMD_QPI_ON)
                & ctrl_reg.quad_enable_bit & ~qpi_reg;
  wire do_qpioff = end_ok & (cmd_reg == qmrpr_pkg::CMD_QPI_OFF) & qpi_reg;
  wire param_ld = (state_reg == qmrpr_pkg::S_PARAM) & byte_done;
  wire wrap_ld  = (state_reg == qmrpr_pkg::S_WRAP) & byte_done
                & (byte_cnt_reg == qmrpr_pkg::WRAP_LAST);

  // ---------------------------------------------------------------
  // Frame state machine
  // ---------------------------------------------------------------
  // A frame that starts while the reset delay runs is skipped whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= qmrpr_pkg::S_IDLE;
      cmd_reg       <= '0;
      cmd_valid_reg <= 1'b0;
      byte_cnt_reg  <= '0;
      dummy_cnt_reg <= '0;
      wrap_rd_reg   <= 1'b0;
    end else if (cs_n_s) begin
      state_reg     <= qmrpr_pkg::S_IDLE;
      cmd_valid_reg <= cmd_valid_reg & ~frame_end;
    end else begin
      case (state_reg)
        qmrpr_pkg::S_IDLE: begin
          cmd_valid_reg <= 1'b0;
          state_reg     <= rst_busy_reg ? qmrpr_pkg::S_SKIP
                                        : qmrpr_pkg::S_CMD;
        end
        qmrpr_pkg::S_CMD: begin
          if (byte_done) begin
            cmd_reg       <= in_next;
            cmd_valid_reg <= 1'b1;
            byte_cnt_reg  <= '0;
            wrap_rd_reg   <= is_wraprd;
            if (is_rdparam) begin
              state_reg <= qmrpr_pkg::S_PARAM;
            end else if (is_setwrap) begin
              state_reg <= qmrpr_pkg::S_WRAP;
            end else if (is_read) begin
              state_reg <= qmrpr_pkg::S_ADDR;
            end else begin
              state_reg <= qmrpr_pkg::S_SKIP;
            end
          end
        end
        qmrpr_pkg::S_ADDR: begin
          if (byte_done) begin
            byte_cnt_reg <= byte_cnt_reg + 2'h1;
            if (byte_cnt_reg == qmrpr_pkg::ADDR_LAST) begin
              state_reg     <= qmrpr_pkg::S_DUMMY;
              dummy_cnt_reg <= '0;
            end
          end
        end
        qmrpr_pkg::S_DUMMY: begin
          if (sclk_rise) begin
            dummy_cnt_reg <= dummy_next;
            if (dummy_next == dummy_need) begin
              state_reg <= qmrpr_pkg::S_DATA;
            end
          end
        end
        qmrpr_pkg::S_WRAP: begin
          if (byte_done) begin
            byte_cnt_reg <= byte_cnt_reg + 2'h1;
            if (wrap_ld) state_reg <= qmrpr_pkg::S_SKIP;
          end
        end
        qmrpr_pkg::S_PARAM: begin
          if (byte_done) state_reg <= qmrpr_pkg::S_SKIP;
        end
        default: begin
          state_reg <= state_reg;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Mode, latch and read settings
  // ---------------------------------------------------------------
  // Mode switches touch only the mode flag, so latch, suspend flag
  // and wrap length ride through unchanged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qpi_reg       <= 1'b0;
      wel_reg       <= 1'b0;
      armed_reg     <= 1'b0;
      rdparam_reg   <= '0;
      wrap_bits_reg <= '0;
    end else if (do_reset) begin
      qpi_reg       <= 1'b0;
      wel_reg       <= 1'b0;
      armed_reg     <= 1'b0;
      rdparam_reg   <= '0;
      wrap_bits_reg <= '0;
    end else begin
      if (do_qpion)  qpi_reg <= 1'b1;
      if (do_qpioff) qpi_reg <= 1'b0;
      if (end_ok && cmd_reg == qmrpr_pkg::CMD_WR_EN)  wel_reg <= 1'b1;
      if (end_ok && cmd_reg == qmrpr_pkg::CMD_WR_DIS) wel_reg <= 1'b0;
      // Any other whole command frame disarms the reset
      if (end_ok) armed_reg <= (cmd_reg == qmrpr_pkg::CMD_RST_EN);
      if (param_ld) rdparam_reg <= in_next;
      if (wrap_ld) begin
        wrap_bits_reg                 <= in_next[6:4];
        rdparam_reg.wrap_length_field <= in_next[6:5];
      end
    end
  end

  // Refusal window after an accepted reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_busy_reg <= 1'b0;
      rst_cnt_reg  <= '0;
    end else if (do_reset) begin
      rst_busy_reg <= 1'b1;
      rst_cnt_reg  <= '0;
    end else if (rst_busy_reg) begin
      rst_cnt_reg  <= rst_cnt_reg + 12'h001;
      rst_busy_reg <= (rst_cnt_reg != qmrpr_pkg::RST_LAST);
    end
  end

  // ---------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------
  logic [7:0] fifo_data;
  logic       fifo_valid;
  logic       fifo_in_ready;
  logic       fifo_push;

  wire [23:0] wrap_mask = (qmrpr_pkg::WRAP_MIN << rdparam_reg.wrap_length_field)
                        - 24'h000001;
  wire [23:0] addr_inc  = addr_reg + 24'h000001;
  wire [23:0] addr_wrap = (addr_reg & ~wrap_mask) | (addr_inc & wrap_mask);
  wire        in_data   = (state_reg == qmrpr_pkg::S_DATA);
  wire        byte_start = in_data & sclk_fall & (out_cnt_reg == 4'h0);
  wire        fifo_pop  = byte_start & fifo_valid;
  // An empty buffer sends fill bytes rather than stalling the link
  wire [7:0]  out_byte  = fifo_valid ? fifo_data : qmrpr_pkg::FILL_BYTE;
  wire [7:0]  cur_byte  = (out_cnt_reg == 4'h0) ? out_byte : out_sh_reg;
  wire [3:0]  out_next  = out_cnt_reg + step;

  // Address collects during the address phase, advances per byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= '0;
    end else if (state_reg == qmrpr_pkg::S_ADDR && byte_done) begin
      addr_reg <= {addr_reg[15:0], in_next};
    end else if (byte_start) begin
      addr_reg <= wrap_rd_reg ? addr_wrap : addr_inc;
    end
  end

  // Output shifter: data change on the falling link edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_sh_reg  <= '0;
      out_cnt_reg <= '0;
      io_out      <= '0;
      io_oe       <= qmrpr_pkg::OE_NONE;
    end else if (!in_data || cs_n_s) begin
      out_cnt_reg <= '0;
      io_oe       <= qmrpr_pkg::OE_NONE;
    end else if (sclk_fall) begin
      io_oe       <= qpi_reg ? qmrpr_pkg::OE_QPI : qmrpr_pkg::OE_SPI;
      io_out      <= qpi_reg ? cur_byte[7:4] : {2'h0, cur_byte[7], 1'h0};
      out_sh_reg  <= qpi_reg ? {cur_byte[3:0], 4'h0} : {cur_byte[6:0], 1'h0};
      out_cnt_reg <= (out_next == qmrpr_pkg::BYTE_BITS) ? 4'h0 : out_next;
    end
  end

  qmrpr_fifo #(
    .WIDTH (qmrpr_pkg::DATA_W),
    .DEPTH (qmrpr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .flush     (do_reset),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  qmrpr_pkg::qmrpr_status_t status;

  wire sel_ctrl  = (paddr == qmrpr_pkg::ADDR_CTRL);
  wire sel_stat  = (paddr == qmrpr_pkg::ADDR_STATUS);
  wire sel_raddr = (paddr == qmrpr_pkg::ADDR_RADDR);
  wire sel_data  = (paddr == qmrpr_pkg::ADDR_DATA);
  wire hit       = sel_ctrl | sel_stat | sel_raddr | sel_data;
  wire apb_req   = psel & penable & ~pready;
  // A data write waits in the access phase while the buffer is full
  wire stall     = sel_data & pwrite & ~fifo_in_ready;
  wire apb_done  = apb_req & ~stall;
  wire ctrl_wr   = apb_done & pwrite & sel_ctrl;
  assign fifo_push = apb_done & pwrite & sel_data;

  assign status.last_cmd               = cmd_reg;
  assign status.read_parameter_byte    = rdparam_reg;
  assign status.wrap_setting_bits      = wrap_bits_reg;
  assign status.wrap_read              = wrap_rd_reg & in_data;
  assign status.reset_busy             = rst_busy_reg;
  assign status.reset_armed            = armed_reg;
  assign status.write_enable_latch     = wel_reg;
  assign status.four_wire_command_mode = qpi_reg;

  wire [31:0] rd_mux = sel_ctrl  ? 32'(ctrl_reg) :
                       sel_stat  ? 32'(status) :
                       sel_raddr ? 32'(addr_reg) : 32'h00000000;

  // Answer one cycle into the access phase unless stalled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= apb_done;
      pslverr <= apb_done & ~hit;
      prdata  <= (apb_done & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Control bits; an accepted reset aborts busy and suspended work
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0;
    end else if (do_reset) begin
      ctrl_reg.busy                  <= 1'b0;
      ctrl_reg.paused_operation_flag <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl_reg <= pwdata[$bits(qmrpr_pkg::qmrpr_ctrl_t)-1:0];
    end
  end

endmodule : qmrpr_top

`default_nettype wire

// File: src/qmrpr_pkg.sv
package qmrpr_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ    = 100;
  localparam int unsigned T_RST_US   = 30;
  localparam int unsigned RST_CYCLES = T_RST_US * CLK_MHZ;
  localparam logic [11:0] RST_LAST   = 12'(RST_CYCLES - 1);

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_RD_PARAM  = 8'hc0;
  localparam logic [7:0] CMD_SET_WRAP  = 8'h77;
  localparam logic [7:0] CMD_FAST_RD   = 8'h0b;
  localparam logic [7:0] CMD_QUAD_RD   = 8'heb;
  localparam logic [7:0] CMD_WRAP_RD   = 8'h0c;
  localparam logic [7:0] CMD_QPI_ON    = 8'h38;
  localparam logic [7:0] CMD_QPI_OFF   = 8'hff;
  localparam logic [7:0] CMD_RST_EN    = 8'h66;
  localparam logic [7:0] CMD_RST       = 8'h99;
  localparam logic [7:0] CMD_WR_EN     = 8'h06;
  localparam logic [7:0] CMD_WR_DIS    = 8'h04;

  // ---------------------------------------------------------------
  // Serial framing
  // ---------------------------------------------------------------
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam logic [3:0]  QPI_STEP    = 4'h4;
  localparam logic [3:0]  SPI_STEP    = 4'h1;
  localparam logic [1:0]  ADDR_LAST   = 2'h2;
  localparam logic [1:0]  WRAP_LAST   = 2'h3;
  localparam logic [3:0]  DUMMY_4     = 4'h4;
  localparam logic [3:0]  DUMMY_6     = 4'h6;
  localparam logic [3:0]  DUMMY_8     = 4'h8;
  localparam logic [3:0]  SPI_DUMMY   = 4'h8;
  localparam logic [23:0] WRAP_MIN    = 24'h000008;
  localparam logic [7:0]  FILL_BYTE   = 8'hff;
  localparam logic [3:0]  OE_QPI      = 4'hf;
  localparam logic [3:0]  OE_SPI      = 4'h2;
  localparam logic [3:0]  OE_NONE     = 4'h0;
  localparam logic [5:0]  SYNC_RST    = 6'h20;

  // ---------------------------------------------------------------
  // Register map and buffer
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RADDR  = 8'h08;
  localparam logic [7:0] ADDR_DATA   = 8'h0c;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FIFO_DEPTH = 4;

  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic [1:0] dummy_cycle_field;
    logic [1:0] rsvd_mid;
    logic [1:0] wrap_length_field;
  } qmrpr_rdparam_t;

  typedef struct packed {
    logic paused_operation_flag;
    logic busy;
    logic quad_enable_bit;
  } qmrpr_ctrl_t;

  typedef struct packed {
    logic [7:0]     last_cmd;
    qmrpr_rdparam_t read_parameter_byte;
    logic [2:0]     wrap_setting_bits;
    logic           wrap_read;
    logic           reset_busy;
    logic           reset_armed;
    logic           write_enable_latch;
    logic           four_wire_command_mode;
  } qmrpr_status_t;

  typedef enum logic [2:0] {
    S_IDLE, S_CMD, S_ADDR, S_DUMMY, S_DATA, S_PARAM, S_WRAP, S_SKIP
  } qmrpr_state_t;

endpackage : qmrpr_pkg

// File: src/qmrpr_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module qmrpr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // Full and empty come from the count, so neither can lie
  assign in_ready  = (count_reg != FULL);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];

  // Storage: one flip-flop row per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_row
    always_ff @(posedge clk) begin
      if (push && wr_ptr_reg == AW'(i)) begin
        mem_reg[i] <= in_data;
      end
    end
  end

  // Pointers and occupancy; flush drops everything at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : qmrpr_fifo

`default_nettype wire

// File: verif/qmrpr_checker.sv
`timescale 1ns/1ns
`default_nettype none
module qmrpr_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cs_n_pin,
  input wire logic [3:0]  io_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answer: one wait state, a single-cycle pulse, quiet data otherwise
  rdy_answer_a: assert property (psel && penable && !pready
    && !(pwrite && paddr == 8'h0c) |=> pready) else $error("bus answer late");
  rdy_pulse_a: assert property (pready |=> !pready) else $error("bus answer held");
  idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
  err_decode_a: assert property (pready |->
    pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c})) else $error("bad error decode");
  err_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("data with error");
  // Drive enables are only off, the serial or the four-wire read pattern
  oe_code_a: assert property (io_oe inside {4'h0, 4'h2, 4'hf}) else $error("odd enable");
  oe_release_a: assert property (cs_n_pin [*5] |-> io_oe == 4'h0) else $error("drives deselected");
  // While the reset delay runs, mode, latch, armed and settings read back clear
  rst_clear_a: assert property (pready && !pwrite && paddr == 8'h04 && prdata[3] |->
    prdata[15:5] == 11'h0 && prdata[2:0] == 3'h0) else $error("state kept over reset");
  cover property (io_oe == 4'hf);
  cover property (pready && pslverr);
  cover property (pready && paddr == 8'h04 && prdata[3]);
endmodule : qmrpr_checker
bind qmrpr_top qmrpr_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .cs_n_pin, .io_oe);
`default_nettype wire

// File: verif/qmrpr_host.sv
`timescale 1ns/1ns
`default_nettype none
module qmrpr_host (
  input  wire logic       pclk,
  input  wire logic [3:0] io_out,
  output logic            cs_n_pin,
  output logic            sclk_pin,
  output logic      [3:0] io_in
);
  // Link idles high and still between frames
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b1;
    io_in    = 4'h0;
  end
  // One 80 ns link clock; sampling just before the next fall keeps sync delay out
  task automatic tick(input logic [3:0] v, output logic [3:0] s);
    // 12.5 MHz link, well inside the slowest dummy setting
    sclk_pin <= 1'b0;
    io_in    <= v;
    repeat (4) @(posedge pclk);
    sclk_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    s = io_out;
  endtask : tick
  // Frame: whole bytes MSB first, dummies, then read bytes
  task automatic xfer(input logic q, input int nb, input logic [39:0] w, input int dum,
                      input int rb, output logic [15:0] rd);
    logic [3:0] s;
    int         st;
    st = q ? 4 : 1;
    rd = 16'h0;
    cs_n_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    for (int i = 0; i < nb * 8; i += st)
      tick(q ? w[39 - i -: 4] : {3'h0, w[39 - i]}, s);
    for (int i = 0; i < dum; i++)
      tick(~io_in, s);
    for (int i = 0; i < rb * 8; i += st) begin
      tick(~io_in, s);
      rd = q ? {rd[11:0], s} : {rd[14:0], s[1]};
    end
    cs_n_pin <= 1'b1;
    io_in    <= ~io_in;
    repeat (6) @(posedge pclk);
  endtask : xfer
endmodule : qmrpr_host
`default_nettype wire

// File: verif/qmrpr_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module qmrpr_top_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cs_n_pin, sclk_pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  io_in, io_out, io_oe;
  logic [15:0] rd;
  logic        e;
  int          n_fail, num_checks, cyc, dm;
  qmrpr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cs_n_pin, .sclk_pin, .io_in, .io_out, .io_oe);
  qmrpr_host host (.pclk, .io_out, .cs_n_pin, .sclk_pin, .io_in);
  always #5 pclk = ~pclk;
  // Hang guard, far above the few thousand cycles the sequence needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Bus transfer: held until pready is seen high, then one idle edge so that
  // a following call never raises psel in the step that lowered it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic st(input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, qmrpr_pkg::ADDR_STATUS, 32'h0);
    chk(r & m, x);
  endtask : st
  task automatic cmd(input logic q, input logic [7:0] c);
    host.xfer(q, 1, {c, 32'h0}, 0, 0, rd);
  endtask : cmd
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h10, 32'h0);
    chk({r[31:1], e}, 32'h1);
    cmd(1'b0, qmrpr_pkg::CMD_QPI_ON);
    st(32'hffef, 32'h0);
    apb(1'b1, qmrpr_pkg::ADDR_CTRL, 32'h1);
    cmd(1'b0, qmrpr_pkg::CMD_WR_EN);
    host.xfer(1'b0, 5, {qmrpr_pkg::CMD_SET_WRAP, 32'h60}, 0, 0, rd);
    cmd(1'b0, qmrpr_pkg::CMD_QPI_ON);
    st(32'hffef, 32'h03c3);
    // Every dummy and wrap code; reads cross the end of each window
    for (int f = 0; f < 4; f++) begin
      dm = (f < 2) ? 4 : 2 + 2 * f;
      host.xfer(1'b1, 2, {qmrpr_pkg::CMD_RD_PARAM, 2'h0, f[1:0], 2'h0, f[1:0], 24'h0},
                0, 0, rd);
      apb(1'b1, qmrpr_pkg::ADDR_DATA, 32'ha5 + f);
      host.xfer(1'b1, 4, {qmrpr_pkg::CMD_WRAP_RD, 32'h3e00}, dm, 2, rd);
      chk({16'h0, rd}, {16'h0, 8'ha5 + 8'(f), 8'hff});
      apb(1'b0, qmrpr_pkg::ADDR_RADDR, 32'h0);
      chk(r, 32'h3e & ~((32'h8 << f) - 32'h1));
    end
    // Quad read takes the same dummy count but runs on past the window
    apb(1'b1, qmrpr_pkg::ADDR_DATA, 32'h3c);
    host.xfer(1'b1, 4, {qmrpr_pkg::CMD_QUAD_RD, 32'h3e00}, 8, 2, rd);
    chk({16'h0, rd}, 32'h3cff);
    apb(1'b0, qmrpr_pkg::ADDR_RADDR, 32'h0);
    chk(r, 32'h40);
    cmd(1'b1, qmrpr_pkg::CMD_QPI_OFF);
    st(32'hff03, 32'h3302);
    // Back in standard mode: fast read with eight dummies on one line
    apb(1'b1, qmrpr_pkg::ADDR_DATA, 32'h5a);
    host.xfer(1'b0, 4, {qmrpr_pkg::CMD_FAST_RD, 32'h3e00}, 8, 1, rd);
    chk({16'h0, rd}, 32'h5a);
    apb(1'b0, qmrpr_pkg::ADDR_RADDR, 32'h0);
    chk(r, 32'h3f);
    cmd(1'b0, qmrpr_pkg::CMD_QPI_ON);
    apb(1'b1, qmrpr_pkg::ADDR_CTRL, 32'h7);
    cmd(1'b1, qmrpr_pkg::CMD_RST);
    st(32'h000f, 32'h3);
    apb(1'b0, qmrpr_pkg::ADDR_CTRL, 32'h0);
    chk(r, 32'h7);
    cmd(1'b1, qmrpr_pkg::CMD_RST_EN);
    cmd(1'b1, qmrpr_pkg::CMD_RST);
    st(32'hffef, 32'h8);
    apb(1'b0, qmrpr_pkg::ADDR_CTRL, 32'h0);
    chk(r, 32'h1);
    cmd(1'b0, qmrpr_pkg::CMD_WR_EN);
    repeat (2700) @(posedge pclk);
    st(32'hffef, 32'h8);
    repeat (300) @(posedge pclk);
    st(32'h000f, 32'h0);
    // Once the window is over, commands act again
    cmd(1'b0, qmrpr_pkg::CMD_WR_EN);
    st(32'h0002, 32'h2);
    cmd(1'b0, qmrpr_pkg::CMD_WR_DIS);
    st(32'h0002, 32'h0);
    finish_test();
  end
endmodule : qmrpr_top_tb_top
`default_nettype wire
